// File: verilog/cadd_cfg.svh
// Functional notes
// - Add-with-carry to memory; W unchanged, one cycle.
// - Add-with-carry to W; memory unchanged, one cycle.
// - Carry set when sum exceeds 0xFF.
// - Digit carry set on bit 3 carry.
// - Zero set on zero result, including 0x100.
// - AND into memory; W unchanged, one cycle.
// - AND into W; memory unchanged, one cycle.
// - AND W with literal, one cycle.
// - AND sets zero only; carries untouched.
// - Halt opcode stops execution, issues no-ops.
// - Halt left only by reset or debug command.
// - Skip-extending halt: halts, skips, two cycles.
// - Call pushes next address, jumps, three cycles.
// - Call target: immediate low, page bits high.
// - Return pops saved address into program counter.
`ifndef CADD_CFG_SVH
`define CADD_CFG_SVH
`define CADD_OFF_INSTR 8'h00
`define CADD_OFF_W 8'h04
`define CADD_OFF_STATUS 8'h08
`define CADD_OFF_PC 8'h0C
`define CADD_OFF_MADDR 8'h10
`define CADD_OFF_MDATA 8'h14
`define CADD_OFF_CTRL 8'h18
`define CADD_OFF_STACK 8'h1C
`define CADD_ST_C_BIT 0
`define CADD_ST_DIGIT_CARRY_BIT 1
`define CADD_ST_Z_BIT 2
`define CADD_ST_PAGE_LO 5
`define CADD_CTRL_RESUME_BIT 0
`define CADD_CTRL_RET_BIT 1
`define CADD_PAT_ADDC_MEM 7'h2F
`define CADD_PAT_ADDC_W 7'h2E
`define CADD_PAT_AND_MEM 7'h0B
`define CADD_PAT_AND_W 7'h0A
`define CADD_PAT_AND_LIT 8'h7E
`define CADD_PAT_BREAK 16'h0001
`define CADD_PAT_BREAKX 16'h0005
`define CADD_PAT_CALL 3'h6
`define CADD_CYC_ONE 2'h1
`define CADD_CYC_BREAKX 2'h2
`define CADD_CYC_CALL 2'h3
`define CADD_RST_W 8'h00
`define CADD_RST_PC 16'h0000
`define CADD_RESP_OKAY 2'h0
`define CADD_RESP_SLVERR 2'h2
`endif

// File: verilog/cadd_pkg.sv
package cadd_pkg;
    typedef enum logic [2:0] {
        CADD_ST_IDLE = 3'b001,
        CADD_ST_EXEC = 3'b010,
        CADD_ST_RESP = 3'b100
    } cadd_state_e;
    typedef enum logic [3:0] {
        CADD_OP_NOP = 4'h0,
        CADD_OP_ADDC_MEM = 4'h1,
        CADD_OP_ADDC_W = 4'h2,
        CADD_OP_AND_MEM = 4'h3,
        CADD_OP_AND_W = 4'h4,
        CADD_OP_AND_LIT = 4'h5,
        CADD_OP_BREAK = 4'h6,
        CADD_OP_BREAKX = 4'h7,
        CADD_OP_CALL = 4'h8
    } cadd_op_e;
    typedef logic [15:0] cadd_word_t;
endpackage

// File: verilog/cadd_core.sv
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "cadd_cfg.svh"
module cadd_core
    import cadd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic halted
);

    cadd_state_e state_reg;
    logic [1:0] cnt_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;
    logic halted_reg;
    logic [7:0] w_reg;
    logic c_reg;
    logic digit_carry_flag_reg;
    logic z_reg;
    logic [2:0] page_reg;
    cadd_word_t pc_reg;
    cadd_word_t op_reg;
    logic [8:0] maddr_reg;
    logic [3:0] sp_reg;
    logic [4:0] depth_reg;
    logic [7:0] dmem [0:511];
    cadd_word_t stack [0:15];

    logic do_wr;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic sel_instr;
    logic sel_w;
    logic sel_status;
    logic sel_pc;
    logic sel_maddr;
    logic sel_mdata;
    logic sel_ctrl;
    logic exec;
    cadd_op_e op_kind;
    logic [7:0] opnd;
    logic [9:0] adc_out;
    logic [7:0] and_out;
    logic [1:0] op_cycles;
    logic resume_cmd;
    logic ret_cmd;
    cadd_word_t stack_top;

    // Decode a 16-bit instruction into the kind that this core executes.
    function automatic cadd_op_e cadd_decode(input cadd_word_t op);
        cadd_op_e k;
        k = CADD_OP_NOP;
        if (op[15:9] == `CADD_PAT_ADDC_MEM) begin
            k = CADD_OP_ADDC_MEM;
        end else if (op[15:9] == `CADD_PAT_ADDC_W) begin
            k = CADD_OP_ADDC_W;
        end else if (op[15:9] == `CADD_PAT_AND_MEM) begin
            k = CADD_OP_AND_MEM;
        end else if (op[15:9] == `CADD_PAT_AND_W) begin
            k = CADD_OP_AND_W;
        end else if (op[15:8] == `CADD_PAT_AND_LIT) begin
            k = CADD_OP_AND_LIT;
        end else if (op == `CADD_PAT_BREAK) begin
            k = CADD_OP_BREAK;
        end else if (op == `CADD_PAT_BREAKX) begin
            k = CADD_OP_BREAKX;
        end else if (op[15:13] == `CADD_PAT_CALL) begin
            k = CADD_OP_CALL;
        end
        return k;
    endfunction

    // Sum with carry in; returns carry, digit carry and the low byte.
    function automatic logic [9:0] cadd_adc(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], h[4], s[7:0]};
    endfunction

    // True for every word offset that holds a register.
    function automatic logic cadd_mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= `CADD_OFF_STACK;
    endfunction

    // Merge a written word into an old value by byte lanes.
    function automatic logic [31:0] cadd_lanes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Write address and data are caught independently, in either order.
    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign do_wr = aw_full_reg && w_full_reg && state_reg == CADD_ST_IDLE;
    assign wr_addr = {awaddr_reg[7:2], 2'h0};
    assign sel_instr = do_wr && wr_addr == `CADD_OFF_INSTR;
    assign sel_w = do_wr && wr_addr == `CADD_OFF_W;
    assign sel_status = do_wr && wr_addr == `CADD_OFF_STATUS;
    assign sel_pc = do_wr && wr_addr == `CADD_OFF_PC;
    assign sel_maddr = do_wr && wr_addr == `CADD_OFF_MADDR;
    assign sel_mdata = do_wr && wr_addr == `CADD_OFF_MDATA;
    assign sel_ctrl = do_wr && wr_addr == `CADD_OFF_CTRL;

    // Holding flops for the write address and data channels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end else if (do_wr) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end else if (do_wr) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // Instructions are ignored while halted; the core only idles then.
    assign exec = sel_instr && !halted_reg;
    assign wr_data = cadd_lanes({16'h0000, op_reg}, wdata_reg, wstrb_reg);
    assign op_kind = cadd_decode(wr_data[15:0]);
    assign opnd = dmem[wr_data[8:0]];
    assign adc_out = cadd_adc(w_reg, opnd, c_reg);
    assign and_out = op_kind == CADD_OP_AND_LIT ? w_reg & wr_data[7:0]
                                                : w_reg & opnd;
    assign resume_cmd = sel_ctrl && wstrb_reg[0] &&
                        wdata_reg[`CADD_CTRL_RESUME_BIT];
    assign ret_cmd = sel_ctrl && wstrb_reg[0] &&
                     wdata_reg[`CADD_CTRL_RET_BIT];
    assign stack_top = stack[sp_reg - 4'h1];

    // Cycle cost of each instruction kind.
    always_comb begin
        unique case (op_kind)
            CADD_OP_BREAKX: op_cycles = `CADD_CYC_BREAKX;
            CADD_OP_CALL: op_cycles = `CADD_CYC_CALL;
            default: op_cycles = `CADD_CYC_ONE;
        endcase
    end

    // The write answer is held back for the instruction's extra cycles.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= CADD_ST_IDLE;
            cnt_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                CADD_ST_IDLE: begin
                    if (do_wr && exec && op_cycles > `CADD_CYC_ONE) begin
                        cnt_reg <= op_cycles - 2'h2;
                        state_reg <= CADD_ST_EXEC;
                    end else if (do_wr) begin
                        state_reg <= CADD_ST_RESP;
                    end
                end
                CADD_ST_EXEC: begin
                    if (cnt_reg == 2'h0) begin
                        state_reg <= CADD_ST_RESP;
                    end else begin
                        cnt_reg <= cnt_reg - 2'h1;
                    end
                end
                CADD_ST_RESP: begin
                    if (bready) begin
                        state_reg <= CADD_ST_IDLE;
                    end
                end
                default: state_reg <= CADD_ST_IDLE;
            endcase
        end
    end

    // An instruction written while halted is refused with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_reg <= `CADD_RESP_OKAY;
        end else if (do_wr) begin
            bresp_reg <= (!cadd_mapped(awaddr_reg) ||
                          (sel_instr && halted_reg)) ?
                         `CADD_RESP_SLVERR : `CADD_RESP_OKAY;
        end
    end
    assign bvalid = state_reg == CADD_ST_RESP;
    assign bresp = bresp_reg;

    // Halt mode: set by either halt opcode, left by resume or reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halted_reg <= 1'b0;
        end else if (exec && (op_kind == CADD_OP_BREAK ||
                              op_kind == CADD_OP_BREAKX)) begin
            halted_reg <= 1'b1;
        end else if (resume_cmd) begin
            halted_reg <= 1'b0;
        end
    end
    assign halted = halted_reg;

    // Last instruction word, kept for read-back even when refused.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_reg <= 16'h0000;
        end else if (sel_instr) begin
            op_reg <= wr_data[15:0];
        end
    end

    // Working register: results of the W forms, or a software write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_reg <= `CADD_RST_W;
        end else if (exec && op_kind == CADD_OP_ADDC_W) begin
            w_reg <= adc_out[7:0];
        end else if (exec && (op_kind == CADD_OP_AND_W ||
                              op_kind == CADD_OP_AND_LIT)) begin
            w_reg <= and_out;
        end else if (sel_w && wstrb_reg[0]) begin
            w_reg <= wdata_reg[7:0];
        end
    end

    // Flags; the AND forms touch only zero, halts and calls none.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_reg <= 1'b0;
            digit_carry_flag_reg <= 1'b0;
            z_reg <= 1'b0;
            page_reg <= 3'h0;
        end else if (exec && (op_kind == CADD_OP_ADDC_MEM ||
                              op_kind == CADD_OP_ADDC_W)) begin
            c_reg <= adc_out[9];
            digit_carry_flag_reg <= adc_out[8];
            z_reg <= adc_out[7:0] == 8'h00;
        end else if (exec && (op_kind == CADD_OP_AND_MEM ||
                              op_kind == CADD_OP_AND_W ||
                              op_kind == CADD_OP_AND_LIT)) begin
            z_reg <= and_out == 8'h00;
        end else if (sel_status && wstrb_reg[0]) begin
            c_reg <= wdata_reg[`CADD_ST_C_BIT];
            digit_carry_flag_reg <= wdata_reg[`CADD_ST_DIGIT_CARRY_BIT];
            z_reg <= wdata_reg[`CADD_ST_Z_BIT];
            page_reg <= wdata_reg[`CADD_ST_PAGE_LO +: 3];
        end
    end

    // Data memory has no reset; software must load it before use.
    always_ff @(posedge aclk) begin
        if (exec && op_kind == CADD_OP_ADDC_MEM) begin
            dmem[wr_data[8:0]] <= adc_out[7:0];
        end else if (exec && op_kind == CADD_OP_AND_MEM) begin
            dmem[wr_data[8:0]] <= and_out;
        end else if (sel_mdata && wstrb_reg[0]) begin
            dmem[maddr_reg] <= wdata_reg[7:0];
        end
    end

    // Data memory pointer; lanes above bit 8 are dropped on purpose.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maddr_reg <= 9'h000;
        end else if (sel_maddr) begin
            maddr_reg <= 9'(cadd_lanes({23'h000000, maddr_reg}, wdata_reg,
                                       wstrb_reg));
        end
    end

    // Program counter and stack; the stack wraps, losing the oldest.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg <= `CADD_RST_PC;
            sp_reg <= 4'h0;
            depth_reg <= 5'h00;
        end else if (exec && op_kind == CADD_OP_CALL) begin
            stack[sp_reg] <= pc_reg + 16'h0001;
            sp_reg <= sp_reg + 4'h1;
            depth_reg <= depth_reg == 5'h10 ? depth_reg
                                            : depth_reg + 5'h01;
            pc_reg <= {page_reg, wr_data[12:0]};
        end else if (exec && op_kind == CADD_OP_BREAKX) begin
            pc_reg <= pc_reg + 16'h0002;
        end else if (exec) begin
            pc_reg <= pc_reg + 16'h0001;
        end else if (ret_cmd && depth_reg != 5'h00) begin
            pc_reg <= stack_top;
            sp_reg <= sp_reg - 4'h1;
            depth_reg <= depth_reg - 5'h01;
        end else if (sel_pc) begin
            pc_reg <= 16'(cadd_lanes({16'h0000, pc_reg}, wdata_reg,
                                     wstrb_reg));
        end
    end

    // Read channel: one read at a time, data registered.
    assign arready = !rvalid_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `CADD_RESP_OKAY;
        end else if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= cadd_mapped(araddr) ? `CADD_RESP_OKAY
                                             : `CADD_RESP_SLVERR;
            unique case ({araddr[7:2], 2'h0})
                `CADD_OFF_INSTR: rdata_reg <= {16'h0000, op_reg};
                `CADD_OFF_W: rdata_reg <= {24'h000000, w_reg};
                `CADD_OFF_STATUS: rdata_reg <= {24'h000000, page_reg,
                    2'h0, z_reg, digit_carry_flag_reg, c_reg};
                `CADD_OFF_PC: rdata_reg <= {16'h0000, pc_reg};
                `CADD_OFF_MADDR: rdata_reg <= {23'h000000, maddr_reg};
                `CADD_OFF_MDATA: rdata_reg <= {24'h000000,
                                               dmem[maddr_reg]};
                `CADD_OFF_CTRL: rdata_reg <= {23'h000000, depth_reg,
                    2'h0, state_reg != CADD_ST_IDLE, halted_reg};
                `CADD_OFF_STACK: rdata_reg <= {16'h0000, stack_top};
                default: rdata_reg <= 32'h00000000;
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // Checks on the execution results and their timing.
    sequence s_call_start;
        exec && op_kind == CADD_OP_CALL;
    endsequence
    sequence s_call_wait;
        (state_reg == CADD_ST_EXEC) [*2] ##1 state_reg == CADD_ST_RESP;
    endsequence

    AST_ADDC_W_SUM: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_ADDC_W |=> w_reg == 8'($past(w_reg) +
        $past(opnd) + {7'h00, $past(c_reg)}))
        else $error("W does not hold the add-with-carry sum.");
    AST_ADDC_MEM_KEEP_W: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_ADDC_MEM |=> $stable(w_reg))
        else $error("W changed on add-with-carry to memory.");
    AST_CARRY_OUT: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_ADDC_MEM |=> c_reg ==
        (({1'b0, $past(w_reg)} + {1'b0, $past(opnd)} +
          {8'h00, $past(c_reg)}) > 9'h0FF))
        else $error("Carry flag wrong after add-with-carry.");
    AST_DIGIT_CARRY: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_ADDC_W |=> digit_carry_flag_reg ==
        (({1'b0, $past(w_reg[3:0])} + {1'b0, $past(opnd[3:0])} +
          {4'h0, $past(c_reg)}) > 5'h0F))
        else $error("Digit carry flag wrong after add-with-carry.");
    AST_ADDC_ZERO: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_ADDC_W |=> z_reg == (w_reg == 8'h00))
        else $error("Zero flag does not match the sum.");
    AST_AND_FLAGS: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_AND_LIT |=> $stable(c_reg) &&
        $stable(digit_carry_flag_reg) && z_reg == (w_reg == 8'h00))
        else $error("AND changed carries or set zero wrongly.");
    AST_AND_LIT: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exec && op_kind == CADD_OP_AND_LIT |=>
        w_reg == ($past(w_reg) & $past(wr_data[7:0])))
        else $error("W does not hold W AND literal.");
    AST_HALT_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        halted_reg && !resume_cmd |=> halted_reg)
        else $error("Halt mode left without a resume command.");
    AST_HALT_STOPS_PC: assert property (
        @(posedge aclk) disable iff (!aresetn)
        halted_reg && sel_instr |=> $stable(pc_reg))
        else $error("Program counter moved while halted.");
    AST_CALL_TARGET: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_call_start |=> pc_reg == {$past(page_reg),
        $past(wr_data[12:0])} && stack_top == $past(pc_reg) + 16'h0001)
        else $error("Call loaded a wrong target or return.");
    AST_CALL_CYCLES: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_call_start |=> s_call_wait)
        else $error("Call did not take three cycles.");
    AST_RETURN_POP: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ret_cmd && depth_reg != 5'h00 |=> pc_reg == $past(stack_top))
        else $error("Return did not restore the saved address.");

endmodule

// File: tb/carry_add_logic_break_call_exec_test.sv
`timescale 1ns/10ps
`include "cadd_cfg.svh"
module carry_add_logic_break_call_exec_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, halted;
    logic [1:0] bresp, rresp, r;
    logic [31:0] d;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int base, n, op;
    logic [8:0] f, sum;
    logic [7:0] wv, dv, st, ew, ed;
    logic [4:0] hs;
    logic [15:0] mpc, ins;
    logic [12:0] k;
    logic [2:0] pg;
    logic ec, edc, ez;
    logic [15:0] q[$];
    logic [15:0] opc[5] = '{16'h5E00, 16'h5C00, 16'h1600, 16'h1400, 16'h7E00};
    logic [15:0] hp[2] = '{`CADD_PAT_BREAK, `CADD_PAT_BREAKX};
    logic [1:0] hc[2] = '{`CADD_CYC_ONE, `CADD_CYC_BREAKX};

    cadd_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .halted(halted));

    // Free-running 200 MHz clock.
    always #2.5 aclk = ~aclk;

    // The full run needs about 1800 cycles, so this ceiling only cuts hangs.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Both ready lines stay high, so each task ends on the answer edge and
    // the next one may start at once without touching a strobe twice.
    task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                      output logic [1:0] rs, output int nc);
        nc = 0;
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            nc++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dt,
                      output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        dt = rdata;
        rs = rresp;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, `CADD_RESP_OKAY});
    endtask

    // Main sequence: reset, random data operations, calls, then halts.
    initial begin
        void'($urandom(32'hA698));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(`CADD_OFF_STATUS, 32'h0);
        rchk(`CADD_OFF_CTRL, 32'h0);
        rd(8'h20, d, r);
        chk({30'h0, r}, {30'h0, `CADD_RESP_SLVERR});
        wr(`CADD_OFF_W, 32'h0, r, base);
        for (int i = 0; i < 64; i++) begin
            op = i % 5;
            f = 9'($urandom);
            dv = 8'($urandom);
            wv = 8'($urandom);
            st = {3'($urandom), 2'b00, 3'($urandom)};
            mpc = 16'($urandom);
            if (i % 8 == 0) begin
                wv = 8'hFF - dv;
                st[0] = 1'b1;
            end
            if (i % 7 == 3) wv = ~dv;
            wr(`CADD_OFF_MADDR, {23'h0, f}, r, n);
            wr(`CADD_OFF_MDATA, {24'h0, dv}, r, n);
            wr(`CADD_OFF_W, {24'h0, wv}, r, n);
            wr(`CADD_OFF_STATUS, {24'h0, st}, r, n);
            wr(`CADD_OFF_PC, {16'h0, mpc}, r, n);
            ins = opc[op] | ((op == 4) ? {8'h0, dv} : {7'h0, f});
            sum = {1'b0, wv} + {1'b0, dv} + {8'h0, st[0]};
            hs = {1'b0, wv[3:0]} + {1'b0, dv[3:0]} + {4'h0, st[0]};
            ew = wv;
            ed = dv;
            {ez, edc, ec} = st[2:0];
            case (op)
                0: ed = sum[7:0];
                1: ew = sum[7:0];
                2: ed = wv & dv;
                default: ew = wv & dv;
            endcase
            if (op < 2) begin
                {ec, edc, ez} = {sum[8], hs[4], sum[7:0] == 8'h00};
            end else begin
                ez = (wv & dv) == 8'h00;
            end
            wr(`CADD_OFF_INSTR, {16'h0, ins}, r, n);
            chk({30'h0, r}, {30'h0, `CADD_RESP_OKAY});
            chk(n, base);
            rchk(`CADD_OFF_W, {24'h0, ew});
            rchk(`CADD_OFF_MDATA, {24'h0, ed});
            st[2:0] = {ez, edc, ec};
            rchk(`CADD_OFF_STATUS,
                 {24'h0, st});
            rchk(`CADD_OFF_PC, {16'h0, mpc + 16'h1});
        end
        // Three nested calls push onto the stack, then returns unwind it in order.
        for (int j = 0; j < 3; j++) begin
            pg = 3'($urandom);
            k = 13'($urandom);
            st = {pg, 2'b00, 3'($urandom)};
            mpc = 16'($urandom);
            wr(`CADD_OFF_STATUS, {24'h0, st}, r, n);
            wr(`CADD_OFF_PC, {16'h0, mpc}, r, n);
            q.push_back(mpc + 16'h1);
            wr(`CADD_OFF_INSTR, {16'h0, 3'h6, k}, r, n);
            chk(n, base + `CADD_CYC_CALL - 1);
            rchk(`CADD_OFF_PC, {16'h0, pg, k});
            rchk(`CADD_OFF_STACK, {16'h0, mpc + 16'h1});
            rchk(`CADD_OFF_STATUS, {24'h0, st});
            rchk(`CADD_OFF_CTRL, (j + 1) << 4);
        end
        while (q.size() > 0) begin
            wr(`CADD_OFF_CTRL, 32'h2, r, n);
            rchk(`CADD_OFF_PC, {16'h0, q.pop_back()});
        end
        // Halt: instructions are refused until resume or reset.
        for (int b = 0; b < 2; b++) begin
            mpc = 16'($urandom);
            wr(`CADD_OFF_W, 32'h5A, r, n);
            wr(`CADD_OFF_STATUS, 32'h07, r, n);
            wr(`CADD_OFF_PC, {16'h0, mpc}, r, n);
            wr(`CADD_OFF_INSTR, {16'h0, hp[b]}, r, n);
            chk(n, base + hc[b] - 1);
            chk(halted, 1'b1);
            rchk(`CADD_OFF_PC, {16'h0, mpc + 16'(hc[b])});
            rchk(`CADD_OFF_STATUS, 32'h07);
            wr(`CADD_OFF_INSTR, 32'h7E00, r, n);
            chk({30'h0, r}, {30'h0, `CADD_RESP_SLVERR});
            rchk(`CADD_OFF_W, 32'h5A);
            rchk(`CADD_OFF_CTRL, 32'h1);
            if (b == 0) begin
                wr(`CADD_OFF_CTRL, 32'h1, r, n);
            end else begin
                aresetn <= 1'b0;
                repeat (2) @(posedge aclk);
                aresetn <= 1'b1;
                @(posedge aclk);
            end
            chk(halted, 1'b0);
        end
        rchk(`CADD_OFF_PC, 32'h0);
        complete_run();
    end
endmodule
